// [rtl/ppf_unit.sv]
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module ppf_unit
    import ppf_pkg::*;
(
    // clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    // register port
    input  wire logic [7:0]        i_reg_addr,
    input  wire logic [31:0]       i_reg_wdata,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    output logic [31:0]            o_reg_rdata,
    // access request
    input  wire logic              i_acc_valid,
    input  wire logic [31:0]       i_acc_addr,
    input  wire logic [2:0]        i_acc_kind,
    input  wire logic              i_acc_super,
    input  wire logic              i_acc_local,
    input  wire logic [ID_W-1:0]   i_acc_id,
    // access result
    output logic                   o_grant_r,
    output logic                   o_block_r,
    output logic                   o_exception
);
    logic [15:0] page_attribute_r [NUM_PAGES];
    logic [PAGE_W-1:0] page_sel;
    logic        allow;
    logic [5:0]  types;
    logic        viol;
    logic [15:0] status_nxt;
    logic [FID_W-1:0] faulting_requestor_id;
    logic        held;
    logic        held_q;
    logic [31:0] fault_address;
    logic [15:0] fault_status;
    logic        clear;
    logic        wr_page;
    logic [PAGE_W-1:0] wr_idx;
    logic [31:0] rdata_nxt;
    logic        exc_r;

    // page index from address bits 7:4, the top of the 8-bit field
    assign page_sel = i_acc_addr[ADDR_W-1 -: PAGE_W];

    ppf_check u_check (
        .i_attr  (page_attribute_r[page_sel]),
        .i_kind  (i_acc_kind),
        // dma requests arrive with the initiator's saved mode
        .i_super (i_acc_super),
        .i_local (i_acc_local),
        .i_id    (i_acc_id),
        .o_allow (allow),
        .o_types (types)
    );

    assign viol = i_acc_valid && !allow;
    // wide ids truncated, local reports zero
    assign faulting_requestor_id = i_acc_local ? FID_W'(0) : i_acc_id[FID_W-1:0];
    always_comb begin
        status_nxt = 16'h0000;
        status_nxt[FID_LSB +: FID_W] = faulting_requestor_id;
        status_nxt[BIT_LOCAL] = i_acc_local;
        status_nxt[5:0] = types;
    end

    // only the clear bit acts; others ignored
    assign clear = i_reg_wr && (i_reg_addr == OFS_FAULT_CMD)
                 && i_reg_wdata[BIT_CLEAR];

    ppf_fault u_fault (
        .i_clock  (i_clock),
        .i_rst    (i_rst),
        .i_viol   (viol),
        .i_addr   (i_acc_addr),
        .i_status (status_nxt),
        .i_clear  (clear),
        .o_held   (held),
        .o_addr   (fault_address),
        .o_status (fault_status)
    );

    // this unit always raises exceptions, so fault registers exist
    // one pulse per recorded fault; later ones are dropped until clear
    always_ff @(posedge i_clock) begin
        if (i_rst)
            held_q <= 1'b0;
        else
            held_q <= held;
    end
    always_ff @(posedge i_clock) begin
        if (i_rst)
            exc_r <= 1'b0;
        else
            exc_r <= held && !held_q;
    end
    assign o_exception = exc_r;

    // access result; blocked writes never reach the array
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_grant_r <= 1'b0;
            o_block_r <= 1'b0;
        end else begin
            o_grant_r <= i_acc_valid && allow;
            o_block_r <= viol;
        end
    end

    assign wr_page = i_reg_wr && (i_reg_addr[7:6] == OFS_PAGE_BASE[7:6]);
    assign wr_idx  = i_reg_addr[PAGE_W+1:2];

    generate
        for (genvar g = 0; g < NUM_PAGES; g++) begin : g_page
            always_ff @(posedge i_clock) begin
                if (i_rst)
                    page_attribute_r[g] <= PAGE_RESET;
                else if (wr_page && wr_idx == PAGE_W'(g))
                    page_attribute_r[g] <= i_reg_wdata[15:0];
            end
        end
    endgenerate

    // read mux; fault regs read only, command reads zero
    always_comb begin
        rdata_nxt = ZERO32;
        if (i_reg_addr[7:6] == OFS_PAGE_BASE[7:6])
            rdata_nxt = {16'h0000, page_attribute_r[wr_idx]};
        else if (i_reg_addr == OFS_FAULT_ADR)
            rdata_nxt = fault_address;
        else if (i_reg_addr == OFS_FAULT_STS)
            rdata_nxt = {16'h0000, fault_status};
        else
            rdata_nxt = ZERO32;
    end
    always_ff @(posedge i_clock) begin
        if (i_rst)
            o_reg_rdata <= ZERO32;
        else if (i_reg_rd)
            o_reg_rdata <= rdata_nxt;
        else
            o_reg_rdata <= ZERO32;
    end

    // assertions
    block_on_viol_a: assert property (@(posedge i_clock) disable iff (i_rst)
        viol |=> o_block_r && !o_grant_r)
        else $error("violation not blocked");
    exc_follows_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (viol && !held && !clear) |=> ##1 o_exception)
        else $error("no exception after violation");
    addr_capture_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (viol && !held && !clear) |=> fault_address == $past(i_acc_addr))
        else $error("fault address wrong");
    hold_fault_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (held && !clear) |=> $stable(fault_address) && $stable(fault_status))
        else $error("fault record changed");
    clear_zero_a: assert property (@(posedge i_clock) disable iff (i_rst)
        clear |=> fault_address == ZERO32 && fault_status == 16'h0000)
        else $error("clear failed");
    ignore_cmd_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_reg_wr && i_reg_addr == OFS_FAULT_CMD
         && !i_reg_wdata[BIT_CLEAR] && held)
        |=> held)
        else $error("bad clear");
    one_exc_a: assert property (@(posedge i_clock) disable iff (i_rst)
        o_exception |=> !o_exception)
        else $error("double exception");
    local_fid_a: assert property (@(posedge i_clock) disable iff (i_rst)
        fault_status[BIT_LOCAL] |-> fault_status[15:9] == 7'h00)
        else $error("local fid nonzero");
    fill_code_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (viol && !held && !clear && i_acc_kind == PPF_FILL)
        |=> fault_status[5:0] == TYPES_FILL)
        else $error("fill code wrong");
    viol_cov: cover property (@(posedge i_clock) viol && !held);
    clear_cov: cover property (@(posedge i_clock) held && clear);
    grant_cov: cover property (@(posedge i_clock) o_grant_r);
    exc_cov: cover property (@(posedge i_clock) o_exception);
endmodule // ppf_unit

// [common/ppf_pkg.sv]
package ppf_pkg;
    localparam int NUM_PAGES   = 16;
    localparam int PAGE_W      = 4;
    localparam int ADDR_W      = 8;
    localparam int ID_W        = 8;
    localparam int FID_W       = 7;
    localparam int NUM_AID     = 6;
    // register map, word aligned byte addresses
    localparam logic [7:0] OFS_PAGE_BASE = 8'h00;
    localparam logic [7:0] OFS_FAULT_ADR = 8'h40;
    localparam logic [7:0] OFS_FAULT_STS = 8'h44;
    localparam logic [7:0] OFS_FAULT_CMD = 8'h48;
    // page attribute, fault status and command fields
    localparam int BIT_UX    = 0;
    localparam int BIT_UW    = 1;
    localparam int BIT_UR    = 2;
    localparam int BIT_SX    = 3;
    localparam int BIT_SW    = 4;
    localparam int BIT_SR    = 5;
    localparam int BIT_LOCAL = 8;
    localparam int BIT_HIGH  = 9;
    localparam int BIT_REQUESTOR0_ALLOW  = 10;
    localparam int FID_LSB   = 9;
    localparam int BIT_CLEAR = 0;
    localparam logic [15:0] PAGE_RESET   = 16'hFF3F;
    localparam logic [5:0]  TYPES_FILL   = 6'h3F;
    localparam logic [5:0]  TYPES_WBACK  = 6'h12;
    localparam logic [31:0] ZERO32       = 32'h0000_0000;
    // access kinds
    typedef enum logic [2:0] {
        PPF_READ  = 3'h0,
        PPF_WRITE = 3'h1,
        PPF_FETCH = 3'h2,
        PPF_FILL  = 3'h3,
        PPF_WBACK = 3'h4
    } ppf_kind_t;
endpackage

// [rtl/ppf_check.sv]
`timescale 1ns/1ps
module ppf_check
    import ppf_pkg::*;
(
    // access
    input  wire logic [15:0]  i_attr,
    input  wire logic [2:0]   i_kind,
    input  wire logic         i_super,
    input  wire logic         i_local,
    input  wire logic [ID_W-1:0] i_id,
    // result
    output logic              o_allow,
    output logic [5:0]        o_types
);
    logic [5:0] need;
    logic       id_ok;
    always_comb begin
        need = 6'h00;
        case (i_kind)
            PPF_READ:  need[i_super ? BIT_SR : BIT_UR] = 1'b1;
            PPF_WRITE: need[i_super ? BIT_SW : BIT_UW] = 1'b1;
            PPF_FETCH: need[i_super ? BIT_SX : BIT_UX] = 1'b1;
            PPF_FILL:  need = TYPES_FILL;
            PPF_WBACK: need = TYPES_WBACK;
            default:   need = TYPES_FILL;
        endcase
    end
    always_comb begin
        if (i_local)
            id_ok = i_attr[BIT_LOCAL];
        else if (i_id < ID_W'(NUM_AID))
            id_ok = i_attr[BIT_REQUESTOR0_ALLOW + int'(i_id[2:0])];
        else
            id_ok = i_attr[BIT_HIGH];
    end
    // each needed bit must be granted independently
    assign o_allow = id_ok && ((need & ~i_attr[5:0]) == 6'h00);
    assign o_types = need;
endmodule // ppf_check

// [rtl/ppf_fault.sv]
`timescale 1ns/1ps
module ppf_fault
    import ppf_pkg::*;
(
    // clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_rst,
    // capture
    input  wire logic         i_viol,
    input  wire logic [31:0]  i_addr,
    input  wire logic [15:0]  i_status,
    input  wire logic         i_clear,
    // record
    output logic              o_held,
    output logic [31:0]       o_addr,
    output logic [15:0]       o_status
);
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_held   <= 1'b0;
            o_addr   <= ZERO32;
            o_status <= 16'h0000;
        end else if (i_clear) begin
            // a fault in the clear cycle is taken next cycle if repeated
            o_held   <= 1'b0;
            o_addr   <= ZERO32;
            o_status <= 16'h0000;
        end else if (i_viol && !o_held) begin
            o_held   <= 1'b1;
            o_addr   <= i_addr;
            o_status <= i_status;
        end
    end
endmodule // ppf_fault

// [bench/ppf_requestor.sv]
`timescale 1ns/1ps
module ppf_requestor
    import ppf_pkg::*;
(
    // clock
    input  wire logic       i_clock,
    // access request
    output logic            o_valid,
    output logic [31:0]     o_addr,
    output logic [2:0]      o_kind,
    output logic            o_super,
    output logic            o_local,
    output logic [ID_W-1:0] o_id
);
    initial begin
        o_valid = 1'b0;
        o_addr  = 32'h0000_0000;
        o_kind  = 3'h0;
        o_super = 1'b0;
        o_local = 1'b0;
        o_id    = 8'h00;
    end
    // one access a call; on release address, id and mode are scrambled, kind and local held
    task automatic issue(input logic [31:0] a, input logic [2:0] k,
        input logic s, input logic l, input logic [ID_W-1:0] id);
        @(posedge i_clock);
        o_valid <= 1'b1;
        o_addr  <= a;
        o_kind  <= k;
        o_super <= s;
        o_local <= l;
        o_id    <= id;
        @(posedge i_clock);
        o_valid <= 1'b0;
        o_addr  <= ~a;
        o_id    <= ~id;
        o_super <= ~s;
    endtask
endmodule // ppf_requestor

// [bench/tb_page_permission_fault_unit.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_page_permission_fault_unit import ppf_pkg::*;;
    logic            clock = 1'b0;
    logic            rst = 1'b1;
    logic [7:0]      ra = 8'h00;
    logic [31:0]     wd = 32'h0000_0000;
    logic            we = 1'b0;
    logic            re = 1'b0;
    logic [31:0]     o_reg_rdata;
    logic            av, asup, aloc, o_grant_r, o_block_r, o_exception;
    logic [31:0]     aadr;
    logic [2:0]      akind;
    logic [ID_W-1:0] aid;
    int              error_cnt = 0;
    int              checks_done = 0;
    int              seed = 32'h6889;

    always #25 clock = ~clock;

    ppf_requestor req (.i_clock(clock), .o_valid(av), .o_addr(aadr),
        .o_kind(akind), .o_super(asup), .o_local(aloc), .o_id(aid));
    ppf_unit DUT (.i_clock(clock), .i_rst(rst), .i_reg_addr(ra),
        .i_reg_wdata(wd), .i_reg_wr(we), .i_reg_rd(re),
        .o_reg_rdata(o_reg_rdata), .i_acc_valid(av), .i_acc_addr(aadr),
        .i_acc_kind(akind), .i_acc_super(asup), .i_acc_local(aloc),
        .i_acc_id(aid), .o_grant_r(o_grant_r), .o_block_r(o_block_r),
        .o_exception(o_exception));

    function automatic logic [5:0] types_of(logic [2:0] k, logic s);
        case (k)
            3'h0: return s ? 6'h20 : 6'h04;
            3'h1: return s ? 6'h10 : 6'h02;
            3'h2: return s ? 6'h08 : 6'h01;
            3'h3: return TYPES_FILL;
            default: return TYPES_WBACK;
        endcase
    endfunction

    function automatic logic ok_of(logic [15:0] at, logic [2:0] k,
        logic s, logic l, logic [7:0] id);
        logic idok;
        idok = l ? at[8] : (id < 8'h06 ? at[10 + id] : at[9]);
        return idok && ((at[5:0] & types_of(k, s)) == types_of(k, s));
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        ra <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clock);
        we <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        ra <= a;
        re <= 1'b1;
        @(posedge clock);
        re <= 1'b0;
        #1;
        `CHK(o_reg_rdata, e)
    endtask

    // held: a fault is already recorded, so no new exception
    task automatic probe(input logic [15:0] at, input logic [31:0] a,
        input logic [2:0] k, input logic s, input logic l,
        input logic [7:0] id, input logic held);
        logic ok;
        ok = ok_of(at, k, s, l, id);
        req.issue(a, k, s, l, id);
        #1;
        `CHK({o_grant_r, o_block_r}, {ok, !ok})
        @(posedge clock);
        #1;
        `CHK(o_exception, !ok && !held)
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        give_verdict();
    end

    initial begin
        logic [15:0] at;
        logic [31:0] a;
        logic [3:0]  pg;
        logic [2:0]  k;
        logic        s, l;
        logic [7:0]  id;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rd_chk(8'h00, {16'h0000, PAGE_RESET});
        rd_chk(OFS_FAULT_ADR, ZERO32);
        rd_chk(OFS_FAULT_CMD, ZERO32);
        rd_chk(8'h4C, ZERO32);
        $display("test reset done");
        wr(8'h00, 32'hFFFF_0000);
        probe(16'h0000, 32'h1234_5600, 3'h0, 1'b1, 1'b0, 8'h03, 1'b0);
        probe(16'h0000, 32'hABCD_0004, 3'h1, 1'b0, 1'b0, 8'h09, 1'b1);
        rd_chk(OFS_FAULT_ADR, 32'h1234_5600);
        wr(OFS_FAULT_ADR, 32'hFFFF_FFFF);
        wr(OFS_FAULT_STS, 32'hFFFF_FFFF);
        wr(OFS_FAULT_CMD, 32'hFFFF_FFFE);
        wr(OFS_FAULT_CMD, 32'h0000_0000);
        rd_chk(OFS_FAULT_ADR, 32'h1234_5600);
        rd_chk(OFS_FAULT_STS, 32'h0000_0620);
        wr(OFS_FAULT_CMD, 32'h0000_0001);
        rd_chk(OFS_FAULT_STS, ZERO32);
        probe(16'h0000, 32'h0000_0008, 3'h2, 1'b0, 1'b1, 8'h07, 1'b0);
        rd_chk(OFS_FAULT_STS, 32'h0000_0101);
        wr(OFS_FAULT_CMD, 32'h0000_0001);
        $display("test held fault done");
        for (int n = 0; n < 60; n++) begin
            pg = 4'($random(seed));
            at = 16'($random(seed));
            // page of every third access wide open so grants occur as well
            if (n % 3 == 0)
                at = at | 16'hFF3F;
            a = $random(seed);
            a[7:4] = pg;
            k = 3'(n % 5);
            s = 1'($random(seed));
            l = (($random(seed) & 3) == 0);
            id = (n % 4 == 0) ? 8'($random(seed)) : 8'(n % 8);
            wr({2'b00, pg, 2'b00}, {16'($random(seed)), at});
            rd_chk({2'b00, pg, 2'b00}, {16'h0000, at});
            probe(at, a, k, s, l, id, 1'b0);
            if (!ok_of(at, k, s, l, id)) begin
                rd_chk(OFS_FAULT_ADR, a);
                rd_chk(OFS_FAULT_STS, {16'h0000, l ? 7'h00 : id[6:0], l,
                    2'b00, types_of(k, s)});
                wr(OFS_FAULT_CMD, 32'h0000_0001);
                rd_chk(OFS_FAULT_ADR, ZERO32);
            end
        end
        $display("test random accesses done");
        give_verdict();
    end
endmodule // tb_page_permission_fault_unit
